/* File: logic/rea_top.sv */
// Reactive energy sign, no-load and accumulation block with Avalon-MM registers
//
// Overview of operation
// RULE1: phase shifter is -90 degrees with integrator on, +90 with it off.
// RULE2: reactive power positive for 0..90 degrees, negative for -90..0, any integrator.
// RULE3: sign change seen on filtered power or per pulse, chosen by sign source bit.
// RULE4: direction bit clear: flag sets on positive-to-negative transition.
// RULE5: direction bit set: flag sets on negative-to-positive transition.
// RULE6: enabled sign flag holds the interrupt until software clears it.
// RULE7: no accumulation while the product is below the no-load threshold.
// RULE8: below threshold sets no-load flag; enabled, it holds the interrupt.
// RULE9: threshold field 00 off, 01/10/11 give 0.015, 0.0075, 0.0037 percent.
// RULE10: 49-bit hidden signed accumulator; energy register shows its upper 24 bits.
// RULE11: one sample added every 5 clock periods.
// RULE12: both mode bits clear: signed accumulation, negative energy subtracts.
// RULE13: both mode bits set: absolute accumulation wins.
// RULE14: anti-tamper adds with active power positive, subtracts when negative; pulses too.
// RULE15: absolute mode accumulates magnitude, skipping no-load samples; pulses too.
// RULE16: product divided by 8-bit divider; zero divides by one.
// RULE17: read-clear register returns energy and clears accumulator upper 24 bits.
// RULE18: energy wraps to 0x800000 going up and 0x7FFFFF going down.
// RULE19: interrupt possible on half-full either sign and on overflow or underflow.
// RULE20: reactive power selectable as waveform source at 27.9, 14, 7, 3.5 kSPS.
// RULE21: after reset accumulation is signed, tamper and absolute off.
// RULE22: sign and no-load detection keep running in tamper and absolute modes.
`include "rea_defines.svh"

module rea_top #(
    parameter int SW = 24,
    parameter int WAVE_BASE_DIV = `REA_CLK_HZ / `REA_WAVE_MAX_SPS
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [9:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire rea_pkg::rea_word_t avs_writedata,
    output rea_pkg::rea_word_t avs_readdata,
    output logic avs_waitrequest,
    input wire logic signed [SW-1:0] product_in,
    input wire logic integrator_enable,
    input wire logic active_power_negative,
    input wire logic pulse_strobe,
    input wire logic pulse_negative,
    output logic phase_shift_negative,
    output logic signed [SW-1:0] pulse_power,
    output logic meter_irq,
    output logic signed [SW-1:0] wave_data,
    output logic wave_valid
);
    import rea_pkg::*;

    localparam int AW = 49;
    localparam int EW = 24;
    localparam int WCW = 16;
    localparam logic [SW-1:0] FULL_SCALE = {1'b0, {(SW - 1){1'b1}}};

    // Elaboration checks; divider, counter and tick widths assume these ranges
    if (SW < 8 || SW > 40) begin : g_bad_sw
        $error("SW must lie between 8 and 40");
    end
    if (WAVE_BASE_DIV < 2 || WAVE_BASE_DIV * 8 > 65535) begin : g_bad_wave_div
        $error("WAVE_BASE_DIV out of range");
    end
    if (`REA_ACC_PERIOD_MCLK < 2 || `REA_ACC_PERIOD_MCLK > 8) begin : g_bad_period
        $error("accumulation period does not fit the tick counter");
    end

    function automatic logic [SW-1:0] mag_of(input logic signed [SW-1:0] v);
        mag_of = v[SW-1] ? SW'(-v) : SW'(v);
    endfunction

    function automatic logic [SW-1:0] thr_of(input int ppm);
        longint t;
        t = (longint'(FULL_SCALE) * longint'(ppm)) / longint'(`REA_PPM_DEN);
        thr_of = SW'(t);
    endfunction

    function automatic logic [EW-1:0] top_of(input logic [AW-1:0] a);
        top_of = a[AW-1:AW-EW];
    endfunction

    // Sign goes back on after the magnitude divide, so the quotient truncates toward zero
    function automatic logic signed [SW-1:0] with_sign(input logic [SW-1:0] m, input logic neg);
        with_sign = neg ? SW'(-m) : SW'(m);
    endfunction

    // Upper two energy bits part company as the register passes half scale either way
    function automatic logic half_cross(input logic [EW-1:0] o, input logic [EW-1:0] n);
        half_cross = (n[EW-1] != n[EW-2]) && (o[EW-1] == o[EW-2]);
    endfunction

    // A wrap counts only when the addend pushes the sign bit in its own direction
    function automatic logic wraps(input logic [EW-1:0] o, input logic [EW-1:0] n, input logic add_neg);
        wraps = (o[EW-1] != n[EW-1]) && (add_neg == o[EW-1]);
    endfunction

    function automatic rea_word_t reg_word(input rea_reg_t r);
        reg_word = {24'h000000, r};
    endfunction

    // Registers
    rea_reg_t wave_cfg_q, nl_cfg_q, acc_cfg_q, gain_cfg_q;
    rea_reg_t irq_en_lo_q, irq_en_hi_q, irq_st_lo_q, div_q;
    logic [AW-1:0] acc_q;
    logic wait_q;
    rea_word_t rdata_q;
    logic [2:0] tick_q;
    logic prev_neg_q;
    logic irq_q;
    logic phase_q;
    logic signed [SW-1:0] pulse_q;
    logic [WCW-1:0] wave_cnt_q;
    logic signed [SW-1:0] wave_data_q;
    logic wave_valid_q;

    // Bus decode
    logic req, access, acc_wr, acc_rd;
    logic rc_hit;
    logic [7:0] idx;
    assign req = avs_read | avs_write;
    assign access = req & ~wait_q;
    assign acc_wr = access & avs_write;
    assign acc_rd = access & avs_read;
    assign idx = avs_address[9:2];
    // Clear strobe only on the accepting edge, never on the wait cycle
    assign rc_hit = acc_rd && idx == `REA_IDX_ENERGY_RC;

    // Sample path
    logic tick;
    logic signed [SW-1:0] q_fixed;
    logic [SW-1:0] q_mag, q_quot, thr;
    logic [7:0] div_eff;
    logic below;
    rea_mode_t mode;
    logic signed [SW-1:0] addend;
    logic [AW-1:0] sum;
    logic [EW-1:0] old_e, new_e;

    // Free-running sample divider, not aligned to bus traffic
    assign tick = (tick_q == 3'(`REA_ACC_PERIOD_MCLK - 1));
    // Integrator-on shifter inverts the product, so fold it back
    assign q_fixed = integrator_enable ? SW'(-product_in) : product_in; // see RULE2
    assign q_mag = mag_of(q_fixed);
    assign div_eff = (div_q == 8'h00) ? 8'h01 : div_q; // see RULE16
    assign q_quot = q_mag / SW'(div_eff); // see RULE16

    // Thresholds fold to constants, so no divider sits in the compare path
    always_comb begin
        case (nl_cfg_q[`REA_NL_HI_BIT:`REA_NL_LO_BIT]) // see RULE9
            2'b01: thr = thr_of(`REA_NL_PPM_01);
            2'b10: thr = thr_of(`REA_NL_PPM_10);
            2'b11: thr = thr_of(`REA_NL_PPM_11);
            default: thr = '0;
        endcase
    end
    // Undivided magnitude, so the divider never moves the no-load point
    assign below = q_mag < thr; // see RULE22

    // Absolute outranks anti-tamper, being the stricter of the two
    always_comb begin
        if (acc_cfg_q[`REA_ACC_ABS_BIT]) begin
            mode = REA_MODE_ABS; // see RULE13
        end else if (acc_cfg_q[`REA_ACC_TAMPER_BIT]) begin
            mode = REA_MODE_TAMPER;
        end else begin
            mode = REA_MODE_SIGNED; // see RULE12
        end
    end

    always_comb begin
        addend = '0;
        if (!below) begin // see RULE7
            case (mode)
                REA_MODE_ABS: addend = q_quot; // see RULE15
                REA_MODE_TAMPER: begin
                    addend = with_sign(q_quot, q_fixed[SW-1] ^ active_power_negative); // see RULE14
                end
                REA_MODE_SIGNED: addend = with_sign(q_quot, q_fixed[SW-1]); // see RULE12
                default: addend = '0;
            endcase
        end
    end

    // Modulo 2^49 add gives the wrap of the visible word
    assign sum = acc_q + {{(AW - SW){addend[SW-1]}}, addend}; // see RULE18
    assign old_e = top_of(acc_q);
    assign new_e = top_of(sum);

    // Events
    logic cur_neg, sign_evt, sign_src, sign_step, half_evt, ovf_evt;
    logic [7:0] st_set, st_clr;
    assign sign_src = gain_cfg_q[`REA_GAIN_SIGN_SRC_BIT];
    // Per-pulse mode compares only at pulses, so ripple between pulses never flags
    assign sign_step = sign_src ? pulse_strobe : tick; // see RULE3
    assign cur_neg = sign_src ? pulse_negative : q_fixed[SW-1]; // see RULE3
    always_comb begin
        sign_evt = 1'b0;
        if (sign_step && (cur_neg != prev_neg_q)) begin // see RULE22
            sign_evt = acc_cfg_q[`REA_ACC_SIGN_DIR_BIT] ? ~cur_neg : cur_neg; // see RULE4 see RULE5
        end
    end
    assign half_evt = tick && half_cross(old_e, new_e); // see RULE19
    assign ovf_evt = tick && wraps(old_e, new_e, addend[SW-1]); // see RULE19
    always_comb begin
        st_set = 8'h00;
        st_set[`REA_IRQ_SIGN_BIT] = sign_evt;
        st_set[`REA_IRQ_NOLOAD_BIT] = tick && below && (thr != '0); // see RULE8
        st_set[`REA_IRQ_HALF_BIT] = half_evt;
        st_set[`REA_IRQ_OVF_BIT] = ovf_evt;
    end
    assign st_clr = (acc_wr && idx == `REA_IDX_IRQST_LO) ? avs_writedata[7:0] : 8'h00;

    // Bus handshake: one wait cycle, then the accepting edge
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            wait_q <= 1'b1;
        end else begin
            wait_q <= ~(req & wait_q);
        end
    end

    // Read word decoded ahead of the latch so the data stands through the answer cycle
    rea_word_t rd_word;
    always_comb begin
        case (idx)
            `REA_IDX_WAVE: rd_word = reg_word(wave_cfg_q);
            `REA_IDX_NOLOAD_MODE_CONFIG: rd_word = reg_word(nl_cfg_q);
            `REA_IDX_ACCUMULATION_MODE_CONFIG: rd_word = reg_word(acc_cfg_q);
            `REA_IDX_GAIN: rd_word = reg_word(gain_cfg_q);
            `REA_IDX_IRQEN_LO: rd_word = reg_word(irq_en_lo_q);
            `REA_IDX_IRQEN_HI: rd_word = reg_word(irq_en_hi_q);
            `REA_IDX_IRQST_LO: rd_word = reg_word(irq_st_lo_q);
            `REA_IDX_ENERGY: rd_word = {8'h00, top_of(acc_q)}; // see RULE10
            `REA_IDX_ENERGY_RC: rd_word = {8'h00, top_of(acc_q)}; // see RULE17
            `REA_IDX_DIV: rd_word = reg_word(div_q);
            default: rd_word = '0;
        endcase
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            rdata_q <= '0;
        end else if (req && wait_q) begin
            rdata_q <= rd_word;
        end
    end

    // Configuration registers
    // Unmapped writes are dropped but still answered
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            wave_cfg_q <= `REA_RST_REG;
            nl_cfg_q <= `REA_RST_REG;
            acc_cfg_q <= `REA_RST_REG; // see RULE21
            gain_cfg_q <= `REA_RST_REG;
            irq_en_lo_q <= `REA_RST_REG;
            irq_en_hi_q <= `REA_RST_REG;
            div_q <= `REA_RST_REG;
        end else if (acc_wr) begin
            case (idx)
                `REA_IDX_WAVE: wave_cfg_q <= avs_writedata[7:0];
                `REA_IDX_NOLOAD_MODE_CONFIG: nl_cfg_q <= avs_writedata[7:0];
                `REA_IDX_ACCUMULATION_MODE_CONFIG: acc_cfg_q <= avs_writedata[7:0];
                `REA_IDX_GAIN: gain_cfg_q <= avs_writedata[7:0];
                `REA_IDX_IRQEN_LO: irq_en_lo_q <= avs_writedata[7:0];
                `REA_IDX_IRQEN_HI: irq_en_hi_q <= avs_writedata[7:0];
                `REA_IDX_DIV: div_q <= avs_writedata[7:0];
                default: ;
            endcase
        end
    end

    // Sticky status, write one to clear; a new event beats the clear
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            irq_st_lo_q <= 8'h00;
        end else begin
            irq_st_lo_q <= (irq_st_lo_q & ~st_clr) | st_set; // see RULE6 see RULE8
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            irq_q <= 1'b0;
        end else begin
            // Registered, so the line trails the status by one cycle
            irq_q <= |(irq_st_lo_q & irq_en_lo_q); // see RULE6 see RULE19
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            tick_q <= 3'h0;
        end else begin
            tick_q <= tick ? 3'h0 : 3'(tick_q + 3'h1); // see RULE11
        end
    end

    // Accumulator; a sample landing on a read-clear keeps only its low bits
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            acc_q <= '0;
        end else begin
            if (rc_hit) begin
                acc_q <= {{EW{1'b0}}, (tick ? sum[AW-EW-1:0] : acc_q[AW-EW-1:0])}; // see RULE17
            end else if (tick) begin
                acc_q <= sum; // see RULE10 see RULE11
            end
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            prev_neg_q <= 1'b0;
        end else if (sign_step) begin
            prev_neg_q <= cur_neg; // see RULE3
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            phase_q <= 1'b0;
            pulse_q <= '0;
        end else begin
            phase_q <= integrator_enable; // see RULE1
            if (tick) begin
                pulse_q <= addend; // see RULE14 see RULE15
            end
        end
    end

    // Waveform sampling; slowest rate is eight times the base period
    // Counter parks at zero while off, so the first sample comes one period after enable
    logic wave_on;
    logic [WCW-1:0] wave_last;
    assign wave_on = irq_en_hi_q[`REA_IRQEN_HI_WAVE_BIT]
        && wave_cfg_q[`REA_WAVE_SRC_HI_BIT:`REA_WAVE_SRC_LO_BIT] == `REA_WAVE_SRC_REACTIVE; // see RULE20
    assign wave_last = WCW'((WAVE_BASE_DIV << wave_cfg_q[`REA_WAVE_RATE_HI_BIT:`REA_WAVE_RATE_LO_BIT]) - 1);

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            wave_cnt_q <= '0;
            wave_valid_q <= 1'b0;
            wave_data_q <= '0;
        end else begin
            wave_valid_q <= 1'b0;
            if (!wave_on || wave_cnt_q >= wave_last) begin
                wave_cnt_q <= '0;
            end else begin
                wave_cnt_q <= WCW'(wave_cnt_q + 1'b1);
            end
            if (wave_on && wave_cnt_q >= wave_last) begin
                wave_valid_q <= 1'b1; // see RULE20
                wave_data_q <= q_fixed;
            end
        end
    end

    assign avs_readdata = rdata_q;
    assign avs_waitrequest = wait_q;
    assign phase_shift_negative = phase_q;
    assign pulse_power = pulse_q;
    assign meter_irq = irq_q;
    assign wave_data = wave_data_q;
    assign wave_valid = wave_valid_q;
endmodule

/* File: common/rea_defines.svh */
// Offsets, field positions, reset values and timing counts of the reactive energy block
`ifndef REA_DEFINES_SVH
`define REA_DEFINES_SVH

`define REA_IDX_WAVE 8'h0D
`define REA_IDX_NOLOAD_MODE_CONFIG 8'h0E
`define REA_IDX_ACCUMULATION_MODE_CONFIG 8'h0F
`define REA_IDX_GAIN 8'h1B
`define REA_IDX_IRQEN_LO 8'hD9
`define REA_IDX_IRQEN_HI 8'hDB
`define REA_IDX_IRQST_LO 8'hDC
`define REA_IDX_ENERGY 8'h40
`define REA_IDX_ENERGY_RC 8'h41
`define REA_IDX_DIV 8'h42

`define REA_RST_REG 8'h00

`define REA_ACC_SIGN_DIR_BIT 0
`define REA_ACC_TAMPER_BIT 1
`define REA_ACC_ABS_BIT 2
`define REA_NL_LO_BIT 0
`define REA_NL_HI_BIT 1
`define REA_GAIN_SIGN_SRC_BIT 7
`define REA_WAVE_RATE_LO_BIT 0
`define REA_WAVE_RATE_HI_BIT 1
`define REA_WAVE_SRC_LO_BIT 2
`define REA_WAVE_SRC_HI_BIT 4
`define REA_WAVE_SRC_REACTIVE 3'h1
`define REA_IRQEN_HI_WAVE_BIT 0
`define REA_IRQ_SIGN_BIT 0
`define REA_IRQ_NOLOAD_BIT 1
`define REA_IRQ_HALF_BIT 2
`define REA_IRQ_OVF_BIT 3

`define REA_NL_PPM_01 150
`define REA_NL_PPM_10 75
`define REA_NL_PPM_11 37
`define REA_PPM_DEN 1000000

`define REA_ACC_PERIOD_MCLK 5
`define REA_CLK_HZ 200000000
`define REA_WAVE_MAX_SPS 27900

`endif

/* File: common/rea_pkg.sv */
// Types shared by the reactive energy block
package rea_pkg;
    typedef logic [7:0] rea_reg_t;
    typedef logic [31:0] rea_word_t;
    typedef enum logic [2:0] {
        REA_MODE_SIGNED = 3'b001,
        REA_MODE_TAMPER = 3'b010,
        REA_MODE_ABS = 3'b100
    } rea_mode_t;
endpackage

/* File: testbench/rea_checker.sv */
// Port-level timing checks for the reactive energy block
module rea_checker #(
    parameter int SW = 24
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [9:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire rea_pkg::rea_word_t avs_writedata,
    input wire rea_pkg::rea_word_t avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic integrator_enable,
    input wire logic phase_shift_negative,
    input wire logic signed [SW-1:0] pulse_power,
    input wire logic meter_irq,
    input wire logic wave_valid
);
    import rea_pkg::*;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    a_wait_one_cycle: assert property ($rose(avs_read || avs_write) |=> !avs_waitrequest)
        else $error("waitrequest not low one cycle after request");
    a_wait_idle_high: assert property (!$past(avs_read || avs_write) && !(avs_read || avs_write) |-> avs_waitrequest)
        else $error("waitrequest low while idle");
    a_phase_follows: assert property (integrator_enable [*2] |-> phase_shift_negative)
        else $error("phase shift sign not following integrator");
    a_irq_mask_off: assert property (avs_write && !avs_waitrequest && avs_address[9:2] == 8'hD9 &&
        avs_writedata[7:0] == 8'h00 |-> ##2 !meter_irq [*2])
        else $error("interrupt stays high with all enables off");
    a_wave_one_cycle: assert property (wave_valid |=> !wave_valid)
        else $error("wave valid longer than one cycle");
    a_tick_spacing: assert property ($changed(pulse_power) |=> $stable(pulse_power) [*4])
        else $error("addend changed between ticks");
    a_rdata_holds: assert property (!avs_waitrequest |=> $stable(avs_readdata))
        else $error("read data moved after answer");
    a_rdata_upper_zero: assert property (avs_read && !avs_waitrequest |-> avs_readdata[31:24] == 8'h00)
        else $error("read data upper byte not zero");
    cover property (avs_read && !avs_waitrequest);
    cover property ($rose(meter_irq));
    cover property (wave_valid);
endmodule

bind rea_top rea_checker #(.SW(SW)) rea_checker_inst (.ref_clk, .rst, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_readdata, .avs_waitrequest, .integrator_enable, .phase_shift_negative, .pulse_power,
    .meter_irq, .wave_valid);

/* File: testbench/rea_host.sv */
// Register bus master standing in for the on-chip core
module rea_host (
    input wire logic ref_clk,
    output logic [9:0] avs_address,
    output logic avs_read,
    output logic avs_write,
    output rea_pkg::rea_word_t avs_writedata,
    input wire rea_pkg::rea_word_t avs_readdata,
    input wire logic avs_waitrequest
);
    timeunit 1ns;
    timeprecision 1ps;
    import rea_pkg::*;
    initial begin
        avs_address = '0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = '0;
    end
    // Held until waitrequest is seen low; the bench timeout ends a hang
    task automatic xfer(input logic w, input logic [7:0] idx, input rea_reg_t d, output rea_word_t q);
        @(posedge ref_clk);
        avs_address <= {idx, 2'b00};
        avs_read <= !w;
        avs_write <= w;
        avs_writedata <= {24'h000000, d};
        do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
endmodule

/* File: testbench/rea_top_tb_top.sv */
// Table-driven and directed tests of the reactive energy block
module rea_top_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import rea_pkg::*;
    localparam int SW = 24;
    typedef struct {rea_reg_t acc; rea_reg_t nl; rea_reg_t dv; int p; logic apn; int e;} rea_row_t;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic [9:0] avs_address;
    logic avs_read, avs_write, avs_waitrequest, phase_shift_negative, meter_irq, wave_valid;
    rea_word_t avs_writedata, avs_readdata, rd_q, e_q;
    logic signed [SW-1:0] product_in = '0;
    logic signed [SW-1:0] pulse_power, wave_data;
    logic integrator_enable = 1'b0, active_power_negative = 1'b0, pulse_strobe = 1'b0, pulse_negative = 1'b0;
    int miscompares = 0, num_checks = 0, cycles = 0;
    // Thresholds at SW=24: 1258, 629, 310
    rea_row_t rows [12] = '{
        '{8'h00, 8'h00, 8'h00, 1000, 1'b0, 1000},
        '{8'h00, 8'h00, 8'h00, -1000, 1'b0, -1000},
        '{8'h02, 8'h00, 8'h00, -1000, 1'b1, 1000},
        '{8'h02, 8'h00, 8'h00, 1000, 1'b1, -1000},
        '{8'h04, 8'h00, 8'h00, -1000, 1'b0, 1000},
        '{8'h06, 8'h00, 8'h00, -1000, 1'b0, 1000},
        '{8'h00, 8'h00, 8'h04, 1000, 1'b0, 250},
        '{8'h00, 8'h00, 8'h03, -1000, 1'b0, -333},
        '{8'h00, 8'h01, 8'h00, 1000, 1'b0, 0},
        '{8'h04, 8'h01, 8'h00, -1000, 1'b0, 0},
        '{8'h00, 8'h02, 8'h00, 1000, 1'b0, 1000},
        '{8'h00, 8'h03, 8'h00, 300, 1'b0, 0}};
    logic [7:0] regs [9] = '{8'h0D, 8'h0E, 8'h0F, 8'h1B, 8'hD9, 8'hDB, 8'hDC, 8'h42, 8'h3F};

    rea_top #(.SW(SW), .WAVE_BASE_DIV(8)) rea_top_inst (.ref_clk, .rst, .avs_address, .avs_read, .avs_write,
        .avs_writedata, .avs_readdata, .avs_waitrequest, .product_in, .integrator_enable, .active_power_negative,
        .pulse_strobe, .pulse_negative, .phase_shift_negative, .pulse_power, .meter_irq, .wave_data, .wave_valid);
    rea_host rea_host_inst (.ref_clk, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata,
        .avs_waitrequest);

    always #2.5 ref_clk = ~ref_clk;

    task automatic wr(input logic [7:0] i, input rea_reg_t d);
        rea_word_t q;
        rea_host_inst.xfer(1'b1, i, d, q);
    endtask
    task automatic rd(input logic [7:0] i);
        rea_host_inst.xfer(1'b0, i, 8'h00, rd_q);
    endtask
    task automatic wait_n(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    task automatic check(input rea_word_t got, input rea_word_t exp, input string m);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch at %0t: %s got %h want %h", $time, m, got, exp);
        end
    endtask
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // Ceiling well above the roughly 1200 cycles the tests need
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            miscompares++;
            report_and_stop();
        end
    end

    initial begin
        wait_n(12);
        rst <= 1'b0;
        foreach (rows[k]) begin
            wr(8'h0F, rows[k].acc);
            wr(8'h0E, rows[k].nl);
            wr(8'h42, rows[k].dv);
            @(posedge ref_clk);
            product_in <= SW'(rows[k].p);
            active_power_negative <= rows[k].apn;
            wait_n(12);
            check(32'(pulse_power), 32'(rows[k].e), "addend");
            wr(8'hDC, 8'hFF);
            wait_n(12);
            rd(8'hDC);
            check(32'(rd_q[1]), 32'(rows[k].e == 0), "no-load flag");
            $display("row %0d done", k);
        end
        // Mid-run reset, then every configuration, status and divider register back to zero
        product_in <= '0;
        rst <= 1'b1;
        wait_n(3);
        rst <= 1'b0;
        foreach (regs[k]) begin
            rd(regs[k]);
            check(rd_q, 32'h00000000, "reset value");
        end
        $display("reset test done");
        for (int d = 0; d < 2; d++) begin
            for (int s = 0; s < 2; s++) begin
                wr(8'h0F, rea_reg_t'(d + 2 * s));
                @(posedge ref_clk);
                product_in <= s ? -24'sd2000 : 24'sd2000;
                wait_n(12);
                wr(8'hDC, 8'hFF);
                @(posedge ref_clk);
                product_in <= s ? 24'sd2000 : -24'sd2000;
                wait_n(12);
                rd(8'hDC);
                check(32'(rd_q[0]), 32'(d == s), "sign flag");
            end
        end
        $display("sign test done");
        for (int k = 0; k < 4; k++) begin
            if (k == 3)
                wr(8'hDC, 8'hFF);
            else
                wr(8'hD9, k == 1 ? 8'h00 : 8'h01);
            wait_n(3);
            check(32'(meter_irq), 32'(k[0] == 1'b0), "sign interrupt");
        end
        wr(8'h0E, 8'h01);
        wr(8'hD9, 8'h02);
        product_in <= 24'sd100;
        wait_n(12);
        check(32'(meter_irq), 32'h1, "no-load interrupt");
        wr(8'hD9, 8'h00);
        wr(8'h0E, 8'h00);
        $display("interrupt test done");
        integrator_enable <= 1'b1;
        wait_n(3);
        check(32'(phase_shift_negative), 32'h1, "phase sign");
        integrator_enable <= 1'b0;
        product_in <= 24'sh7FFFFF;
        wait_n(400);
        product_in <= '0;
        wait_n(12);
        rd(8'h40);
        e_q = rd_q;
        check(32'(e_q == 32'd19 || e_q == 32'd20), 32'h1, "energy after 80 full-scale samples");
        rd(8'h41);
        check(rd_q, e_q, "read-clear value");
        rd(8'h40);
        check(rd_q, 32'h00000000, "energy after clear");
        $display("energy test done");
        product_in <= 24'sd5000;
        wr(8'h0D, 8'h04);
        wr(8'hDB, 8'h01);
        for (int n = 0; n < 100 && wave_valid !== 1'b1; n++)
            @(posedge ref_clk);
        check(32'(wave_data), 32'd5000, "wave sample");
        $display("wave test done");
        wr(8'h0F, 8'h00);
        wr(8'h1B, 8'h80);
        for (int n = 0; n < 2; n++) begin
            pulse_negative <= n[0];
            pulse_strobe <= 1'b1;
            @(posedge ref_clk);
            pulse_strobe <= 1'b0;
            if (n == 0)
                wr(8'hDC, 8'hFF);
        end
        rd(8'hDC);
        check(32'(rd_q[0]), 32'h1, "per-pulse sign flag");
        $display("pulse sign test done");
        report_and_stop();
    end
endmodule
